// ### rtl/paov_pkg.sv
package paov_pkg;
  // Number of port pins handled by the override block.
  localparam int PAOV_PINS = 8;
  // Pin positions within the port.
  localparam int PAOV_PIN_RX = 0;
  localparam int PAOV_PIN_TX = 1;
  localparam int PAOV_PIN_MISO = 2;
  localparam int PAOV_PIN_MOSI = 4;
  localparam int PAOV_PIN_SCK = 5;
  // Value of the pad direction outputs after reset.
  localparam logic [7:0] PAOV_RST_BYTE = 8'h00;
endpackage

// ### rtl/paov_ovr_if.sv
`timescale 1ns/1ps
// Per-pin override enables and values passed from the override logic to the pad mux.
interface paov_ovr_if;
  logic [7:0] puoe;
  logic [7:0] puov;
  logic [7:0] ddoe;
  logic [7:0] ddov;
  logic [7:0] pvoe;
  logic [7:0] pvov;
  modport src (output puoe, puov, ddoe, ddov, pvoe, pvov);
  modport dst (input puoe, puov, ddoe, ddov, pvoe, pvov);
endinterface

// ### rtl/paov_pad_mux.sv
`timescale 1ns/1ps
// Per-pin selection between override values and the ordinary port path.
module paov_pad_mux
  import paov_pkg::*;
(
  paov_ovr_if.dst ovr,
  input wire logic [7:0] i_ddr,
  input wire logic [7:0] i_port,
  input wire logic i_pud,
  output logic [7:0] o_dir,
  output logic [7:0] o_out,
  output logic [7:0] o_pull
);
  // Each pin takes its override only while its enable is set.
  for (genvar g = 0; g < PAOV_PINS; g++) begin : g_pin
    always_comb begin
      o_dir[g] = ovr.ddoe[g] ? ovr.ddov[g] : i_ddr[g];
      o_out[g] = ovr.pvoe[g] ? ovr.pvov[g] : i_port[g];
      o_pull[g] = ovr.puoe[g] ? ovr.puov[g] : (i_port[g] & ~i_ddr[g] & ~i_pud);
    end
  end
endmodule

// ### rtl/paov_top.sv
`timescale 1ns/1ps
// Behaviour
// - An enabled UART transmitter forces pin 1 to output.
// - An enabled LIN function forces pin 1 to output.
// - Pin 1 pull-up follows its latch while input unless pull-ups are globally off.
// - LIN transmit enable forces pin 1 pull-up off, else latch gated by input direction and global disable.
// - LIN transmit enable drives pin 1 with LIN transmit data, else override value zero.
// - An enabled UART receiver forces pin 0 to input.
// - An enabled LIN function forces pin 0 to input.
// - With pin 0 forced to input, a one in its latch turns on the pull-up unless pull-ups are globally off.
// - Pin 2 output is SPI master data, else serial shift output, else timer-0 compare.
// - Pin 5 output is SPI clock in master mode, else low with two-wire, position and dir5 all set, else its latch.
// - Pin 4 output is SPI data in master mode, else low with two-wire, position and dir4 all set, else its latch.
// - Pin 5 input feeds pin change, timer-1 clock, serial clock and SPI clock inputs.
// - Pin 4 input feeds pin change, timer-1 capture, serial data and SPI data inputs.
module paov_top
  import paov_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_ddr,
  input wire logic [7:0] i_port,
  input wire logic [7:0] i_pin_in,
  input wire logic i_global_pullup_disable,
  input wire logic i_uart_tx_enable,
  input wire logic i_uart_rx_enable,
  input wire logic i_lin_enable,
  input wire logic i_lin_transmit_pin,
  input wire logic i_spi_enable_bit,
  input wire logic i_spi_master_select,
  input wire logic i_spi_sck_out,
  input wire logic i_spi_mosi_out,
  input wire logic i_spi_miso_out,
  input wire logic i_serial_shift_output,
  input wire logic i_serial_two_wire_mode,
  input wire logic i_serial_three_wire_mode,
  input wire logic i_serial_alternate_position,
  input wire logic i_serial_scl_hold,
  input wire logic i_timer0_compare_output,
  output logic [7:0] o_pad_dir,
  output logic [7:0] o_pad_out,
  output logic [7:0] o_pad_pull,
  output logic [7:0] o_pin_change_src,
  output logic o_lin_receive_pin,
  output logic o_timer1_clock_input,
  output logic o_serial_three_wire_clock,
  output logic o_spi_sck_in,
  output logic o_timer1_capture_trigger,
  output logic o_serial_data_in,
  output logic o_spi_mosi_in
);
  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0] pull;
    logic [7:0] pcint;
    logic rx;
    logic t1;
    logic serial_three_wire_clock;
    logic sck;
    logic icp;
    logic di;
    logic mosi;
  } paov_state_t;

  paov_state_t st;
  paov_state_t next_st;
  paov_ovr_if ovr ();
  logic [7:0] mux_dir;
  logic [7:0] mux_out;
  logic [7:0] mux_pull;
  logic spi_m;
  logic tx_en;
  logic rx_en;
  logic tw5;
  logic tw4;

  //----------------------------------------------------------------
  // Override generation
  //----------------------------------------------------------------
  // Common qualifiers for the override terms.
  assign spi_m = i_spi_enable_bit & i_spi_master_select;
  assign tx_en = i_uart_tx_enable | i_lin_enable;
  assign rx_en = i_uart_rx_enable | i_lin_enable;
  assign tw5 = i_serial_two_wire_mode & i_serial_alternate_position & i_ddr[PAOV_PIN_SCK];
  assign tw4 = i_serial_two_wire_mode & i_serial_alternate_position & i_ddr[PAOV_PIN_MOSI];

  // Fill the override enables and values for each pin; unused pins keep normal logic.
  always_comb begin
    ovr.puoe = 8'h00;
    ovr.puov = 8'h00;
    ovr.ddoe = 8'h00;
    ovr.ddov = 8'h00;
    ovr.pvoe = 8'h00;
    ovr.pvov = 8'h00;
    // Pin 0: receive functions force input, pull-up from latch.
    ovr.ddoe[PAOV_PIN_RX] = rx_en;
    ovr.puoe[PAOV_PIN_RX] = rx_en;
    ovr.puov[PAOV_PIN_RX] = i_port[PAOV_PIN_RX] & ~i_global_pullup_disable;
    // Pin 1: transmit functions force output and drive LIN data.
    ovr.ddoe[PAOV_PIN_TX] = tx_en;
    ovr.ddov[PAOV_PIN_TX] = tx_en;
    ovr.puoe[PAOV_PIN_TX] = tx_en;
    ovr.puov[PAOV_PIN_TX] = 1'b0;
    ovr.pvoe[PAOV_PIN_TX] = tx_en;
    ovr.pvov[PAOV_PIN_TX] = tx_en ? i_lin_transmit_pin : 1'b0;
    // Pin 2: priority choice of output source.
    ovr.ddoe[PAOV_PIN_MISO] = spi_m;
    ovr.pvoe[PAOV_PIN_MISO] = 1'b1;
    ovr.pvov[PAOV_PIN_MISO] = spi_m ? i_spi_miso_out :
        (i_serial_three_wire_mode ? i_serial_shift_output : i_timer0_compare_output);
    // Pin 4: SPI data out or two-wire open-drain low.
    ovr.pvoe[PAOV_PIN_MOSI] = spi_m | tw4;
    ovr.pvov[PAOV_PIN_MOSI] = spi_m ? i_spi_mosi_out : ~tw4;
    // Pin 5: SPI clock out or two-wire open-drain low.
    ovr.pvoe[PAOV_PIN_SCK] = spi_m | tw5;
    ovr.pvov[PAOV_PIN_SCK] = spi_m ? i_spi_sck_out : ~tw5;
    ovr.ddoe[PAOV_PIN_SCK] = i_serial_two_wire_mode & i_serial_alternate_position;
    ovr.ddov[PAOV_PIN_SCK] = (i_serial_scl_hold | i_port[PAOV_PIN_SCK]) & i_ddr[PAOV_PIN_SCK];
  end

  paov_pad_mux u_mux (
    .ovr(ovr),
    .i_ddr(i_ddr),
    .i_port(i_port),
    .i_pud(i_global_pullup_disable),
    .o_dir(mux_dir),
    .o_out(mux_out),
    .o_pull(mux_pull)
  );

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  // Register pad controls and route digital inputs to their consumers.
  always_comb begin
    next_st = st;
    next_st.dir = mux_dir;
    next_st.out = mux_out;
    next_st.pull = mux_pull;
    next_st.pcint = i_pin_in;
    next_st.rx = i_pin_in[PAOV_PIN_RX];
    next_st.t1 = i_pin_in[PAOV_PIN_SCK];
    next_st.serial_three_wire_clock = i_pin_in[PAOV_PIN_SCK];
    next_st.sck = i_pin_in[PAOV_PIN_SCK];
    next_st.icp = i_pin_in[PAOV_PIN_MOSI];
    next_st.di = i_pin_in[PAOV_PIN_MOSI];
    next_st.mosi = i_pin_in[PAOV_PIN_MOSI];
  end

  // State register with synchronous reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st <= '0;
      st.dir <= PAOV_RST_BYTE;
    end else begin
      st <= next_st;
    end
  end

  assign o_pad_dir = st.dir;
  assign o_pad_out = st.out;
  assign o_pad_pull = st.pull;
  assign o_pin_change_src = st.pcint;
  assign o_lin_receive_pin = st.rx;
  assign o_timer1_clock_input = st.t1;
  assign o_serial_three_wire_clock = st.serial_three_wire_clock;
  assign o_spi_sck_in = st.sck;
  assign o_timer1_capture_trigger = st.icp;
  assign o_serial_data_in = st.di;
  assign o_spi_mosi_in = st.mosi;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_tx_dir_out: assert property (i_uart_tx_enable |=> o_pad_dir[1])
    else $error("pin 1 not output with uart tx");
  a_lin_dir_out: assert property (i_lin_enable |=> o_pad_dir[1] && !o_pad_dir[0])
    else $error("lin did not force pin directions");
  a_tx_pull_norm: assert property (!tx_en && !i_ddr[1] |=> o_pad_pull[1] ==
      ($past(i_port[1]) && !$past(i_global_pullup_disable))) else $error("pin 1 pull wrong");
  a_tx_pull_off: assert property (tx_en |=> !o_pad_pull[1])
    else $error("pin 1 pull not off");
  a_tx_data: assert property (tx_en |=> o_pad_out[1] == $past(i_lin_transmit_pin))
    else $error("pin 1 data wrong");
  a_rx_dir_in: assert property (i_uart_rx_enable |=> !o_pad_dir[0])
    else $error("pin 0 not input");
  a_rx_dir_lin: assert property (i_lin_enable && !i_uart_rx_enable |=> !o_pad_dir[0])
    else $error("pin 0 not input with lin");
  a_rx_pull: assert property (rx_en && i_port[0] && !i_global_pullup_disable
      |=> o_pad_pull[0]) else $error("pin 0 pull missing");
  a_miso_prio: assert property (spi_m |=> o_pad_out[2] == $past(i_spi_miso_out))
    else $error("pin 2 priority wrong");
  a_sck_out: assert property (spi_m |=> o_pad_out[5] == $past(i_spi_sck_out))
    else $error("pin 5 clock wrong");
  a_mosi_out: assert property (!spi_m && tw4 |=> !o_pad_out[4])
    else $error("pin 4 two-wire low missing");
  a_in5_route: assert property (##1 o_timer1_clock_input == $past(i_pin_in[5]))
    else $error("pin 5 input route wrong");
  a_in4_route: assert property (##1 o_spi_mosi_in == $past(i_pin_in[4]))
    else $error("pin 4 input route wrong");
  a_pin_normal: assert property (!spi_m && !tx_en && !rx_en &&
      !(i_serial_two_wire_mode && i_serial_alternate_position) |=>
      o_pad_dir == $past(i_ddr)) else $error("normal direction not kept");
endmodule

// ### verif/paov_pad_model.sv
`timescale 1ns/1ps
// Pad model: a driven pad shows its output, a pulled pad reads one, else the outside level.
module paov_pad_model (
  input wire logic [7:0] i_dir,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_pull,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_pin
);
  // Resolves each pad level from the block's drive and pull controls.
  always_comb begin
    o_pin = (i_dir & i_out) | (~i_dir & (i_pull | i_ext));
  end
endmodule

// ### verif/paov_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the port override block.
module paov_top_tb
  import paov_pkg::*;
;
  logic clk;
  logic rst;
  logic [15:0] ctl;
  logic [7:0] ddr;
  logic [7:0] port;
  logic [7:0] ext;
  logic [7:0] pin;
  logic [7:0] dir;
  logic [7:0] pout;
  logic [7:0] pull;
  logic [7:0] pcs;
  logic [6:0] rt;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  paov_top u_paov_top (.i_sys_clk(clk), .i_rst(rst), .i_ddr(ddr), .i_port(port), .i_pin_in(pin),
    .i_global_pullup_disable(ctl[15]), .i_uart_tx_enable(ctl[0]), .i_uart_rx_enable(ctl[1]),
    .i_lin_enable(ctl[2]), .i_lin_transmit_pin(ctl[3]), .i_spi_enable_bit(ctl[4]),
    .i_spi_master_select(ctl[5]), .i_spi_sck_out(ctl[6]), .i_spi_mosi_out(ctl[7]),
    .i_spi_miso_out(ctl[8]), .i_serial_shift_output(ctl[9]), .i_serial_two_wire_mode(ctl[10]),
    .i_serial_three_wire_mode(ctl[11]), .i_serial_alternate_position(ctl[12]),
    .i_serial_scl_hold(ctl[13]), .i_timer0_compare_output(ctl[14]), .o_pad_dir(dir),
    .o_pad_out(pout), .o_pad_pull(pull), .o_pin_change_src(pcs), .o_lin_receive_pin(rt[6]),
    .o_timer1_clock_input(rt[5]), .o_serial_three_wire_clock(rt[4]), .o_spi_sck_in(rt[3]),
    .o_timer1_capture_trigger(rt[2]), .o_serial_data_in(rt[1]), .o_spi_mosi_in(rt[0]));
  paov_pad_model u_paov_pad_model (.i_dir(dir), .i_out(pout), .i_pull(pull), .i_ext(ext),
    .o_pin(pin));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Expected pad controls as {dir, out, pull}; ctl bit 15 is the global pull-up disable.
  function automatic logic [23:0] f_exp(input logic [15:0] c, input logic [7:0] d,
    input logic [7:0] p);
    logic [7:0] dr;
    logic [7:0] ou;
    logic [7:0] pu;
    logic o1;
    logic o0;
    logic sm;
    o1 = c[0] | c[2];
    o0 = c[1] | c[2];
    sm = c[4] & c[5];
    dr = {d[7:6], (c[10] & c[12]) ? (c[13] | p[5]) & d[5] : d[5], d[4:3], sm ? 1'b0 : d[2],
      o1 | d[1], o0 ? 1'b0 : d[0]};
    pu = p & ~d & {8{~c[15]}};
    pu[1] = pu[1] & ~o1;
    pu[0] = o0 ? p[0] & ~c[15] : pu[0];
    ou = p;
    ou[1] = o1 ? c[3] : p[1];
    ou[2] = sm ? c[8] : (c[11] ? c[9] : c[14]);
    ou[4] = (sm | (c[10] & c[12] & d[4])) ? sm & c[7] : p[4];
    ou[5] = (sm | (c[10] & c[12] & d[5])) ? sm & c[6] : p[5];
    return {dr, ou, pu};
  endfunction

  // Drives one setting and compares all pad controls one cycle later.
  task automatic apply(input logic [15:0] cv, input logic [7:0] dv, input logic [7:0] pv);
    logic [23:0] e;
    e = f_exp(cv, dv, pv);
    @(posedge clk);
    ctl <= cv;
    ddr <= dv;
    port <= pv;
    @(posedge clk);
    #1;
    chk("pad_dir", e[23:16], dir);
    chk("pad_out", e[15:8], pout);
    chk("pad_pull", e[7:0], pull);
  endtask

  task automatic sc_pin1();
    logic [15:0] t [7] = '{16'h0, 16'h1, 16'h4, 16'h9, 16'hC, 16'h8004, 16'h8000};
    for (int i = 0; i < 7; i++) begin
      apply(t[i], 8'h00, 8'hFF);
      apply(t[i], 8'h02, 8'h03);
    end
  endtask

  task automatic sc_pin0();
    logic [15:0] t [5] = '{16'h0, 16'h2, 16'h4, 16'h8002, 16'h8004};
    for (int i = 0; i < 5; i++) begin
      apply(t[i], 8'hFF, 8'h01);
      apply(t[i], 8'hFE, 8'h00);
    end
  endtask

  task automatic sc_pin2();
    logic [5:0] b;
    for (int i = 0; i < 64; i++) begin
      b = 6'(i);
      apply({1'b0, b[5], 2'b0, b[4], 1'b0, b[3], b[2], 2'b0, b[1], b[0], 4'h0}, 8'h04, 8'h04);
    end
  endtask

  task automatic sc_pin45();
    logic [6:0] b;
    logic [15:0] cv;
    for (int i = 0; i < 128; i++) begin
      b = 7'(i);
      cv = {3'b0, b[5], 1'b0, b[4], 2'b0, b[3], b[2], b[1], b[0], 4'h0};
      apply(cv, {2'b0, {2{b[6]}}, 4'h0}, 8'h30);
    end
  endtask

  // Pin 5 direction with two-wire mode, position, clock hold and latch all varied.
  task automatic sc_pin5_dir();
    logic [3:0] b;
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      apply({2'b0, b[3], b[2], 1'b0, b[1], 10'h000}, 8'h20, {2'b0, b[0], 5'h00});
    end
  endtask

  task automatic sc_route();
    logic [7:0] v;
    apply(16'h0, 8'h00, 8'h00);
    for (int i = 0; i < 2; i++) begin
      v = (i == 1) ? 8'hA5 : 8'h5A;
      @(posedge clk);
      ext <= v;
      @(posedge clk);
      #1;
      chk("pin_change", v, pcs);
      chk("routed", {1'b0, v[0], {3{v[5]}}, {3{v[4]}}}, {1'b0, rt});
    end
  endtask

  // Reset for three cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    ctl = 16'h0;
    ddr = 8'h00;
    port = 8'h00;
    ext = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    chk("reset_dir", PAOV_RST_BYTE, dir);
    @(posedge clk);
    rst <= 1'b0;
    sc_pin1();
    sc_pin0();
    sc_pin2();
    sc_pin45();
    sc_pin5_dir();
    sc_route();
    close_out();
  end
endmodule
